//--- hw/rri_top.sv
// Our own choices: the placing of the registers and the AHB-Lite register port.
`default_nettype none
`include "rri_map.svh"
// Overview of operation
// - Interrupt wake with enable loads vector
// - Interrupt wake with enable pushes counter, advances stack
// - Interrupt wake needs a set flag
// - Port A bits 6, 7 gated by oscillator
// - Fuse picks analog select zeros or ones
// - Unimplemented bits always read zero
// - Condition bits follow the reset condition
module rri_top
  import rri_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic srst,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Reset and wake events from the core.
  input wire logic init_req,
  input wire rri_cause_t init_cause,
  input wire logic irq_high_prio,
  input wire logic [`RRI_PC_W-1:0] current_pc,
  input wire logic [7:0] int_flag_set,
  input wire logic [7:0] periph_flag_set,
  // Condition inputs and configuration.
  input wire logic osc_cond_bit,
  input wire logic [7:0] reset_cause_cond,
  input wire logic port_b_analog_fuse,
  input wire logic osc_frees_pa67,
  // Port A pins.
  input wire logic [7:0] port_a_pins,
  // Results.
  output logic pc_load,
  output logic [`RRI_PC_W-1:0] pc_load_addr,
  output logic [`RRI_PC_W-1:0] stack_top,
  output logic [7:0] return_stack_pointer,
  output logic high_priority_global_enable,
  output logic low_priority_global_enable,
  output logic [2:0] analog_pin_select,
  output logic [7:0] port_a_latch,
  output logic [7:0] port_a_direction
);
  localparam rri_init_t INIT_TAB [0:`RRI_NREG-1] = '{
    `RRI_INIT_NIB_ZERO, `RRI_INIT_KEEP_ALL, `RRI_INIT_NIB_ZERO,
    `RRI_INIT_NONE, `RRI_INIT_NONE, `RRI_INIT_NONE, `RRI_INIT_NONE, `RRI_INIT_NONE,
    `RRI_INIT_NIB_ZERO, `RRI_INIT_KEEP_ALL, `RRI_INIT_ALU,
    `RRI_INIT_BYTE_ZERO, `RRI_INIT_KEEP_ALL, `RRI_INIT_BYTE_ONES,
    `RRI_INIT_OSC, `RRI_INIT_VDET, `RRI_INIT_WDOG, `RRI_INIT_RCAUSE,
    `RRI_INIT_KEEP_ALL, `RRI_INIT_KEEP_ALL, `RRI_INIT_TMR1_CTL,
    `RRI_INIT_BYTE_ZERO, `RRI_INIT_TIMER_TWO_COUNT_PER, `RRI_INIT_TIMER_TWO_COUNT_CTL,
    `RRI_INIT_KEEP_ALL, `RRI_INIT_BYTE_ZERO, `RRI_INIT_BYTE_ZERO,
    `RRI_INIT_BYTE_ZERO, `RRI_INIT_BYTE_ZERO,
    `RRI_INIT_INT_CTL, `RRI_INIT_BYTE_ZERO, `RRI_INIT_ANALOG,
    `RRI_INIT_KEEP_ALL, `RRI_INIT_BYTE_ONES
  };

  rri_wake_if wk_if ();

  logic [7:0] regs_r [0:`RRI_NREG-1];
  logic [7:0] regs_nxt [0:`RRI_NREG-1];
  logic [7:0] cond_val [0:`RRI_NREG-1];
  logic [7:0] pins_meta_r;
  logic [7:0] pins_sync_r;
  logic wr_pend_r;
  logic [5:0] wr_idx_r;
  logic [31:0] hrdata_r;
  logic pc_load_r;

  wire addr_phase;
  wire [5:0] addr_idx;
  wire [7:0] pa_mask;
  wire [7:0] int_flags_now;
  wire flag_pending;
  wire wake_refused;
  wire apply;
  wire [7:0] rd_byte;
  wire [7:0] rd_array;
  wire rd_in_array;

  // A transfer is taken when selected, valid and the bus is ready.
  assign addr_phase = hsel && hready && (htrans[1] == `RRI_HTRANS_NONSEQ);
  assign addr_idx = haddr[`RRI_IDX_MSB:2];

  assign pa_mask = osc_frees_pa67 ? `RRI_PA_FULL_MASK : `RRI_PA_LOW_MASK;

  assign int_flags_now = (regs_r[`RRI_IDX_INT_CTL] | int_flag_set) & `RRI_INT_FLAG_MASK;
  assign flag_pending = (|int_flags_now) || (|regs_r[`RRI_IDX_PERIPH_FLAG]) || (|periph_flag_set);
  assign wake_refused = (init_cause == RRI_CAUSE_WAKE_IRQ) && !flag_pending;
  assign apply = init_req && !wake_refused;

  // Condition-dependent source values, placed at their bit positions.
  always_comb begin
    for (int i = 0; i < `RRI_NREG; i++) begin
      cond_val[i] = 8'h00;
    end
    cond_val[`RRI_IDX_OSC_CTL][`RRI_OSC_COND_BIT] = osc_cond_bit;
    cond_val[`RRI_IDX_RCAUSE] = reset_cause_cond;
    cond_val[`RRI_IDX_ANALOG_CFG] = port_b_analog_fuse ? `RRI_ANALOG_FUSE_SET : `RRI_ANALOG_FUSE_CLR;
  end

  // Next value of every stored register: bus write, then the initialization set,
  // then flag sets. Computed once so the read path can forward it.
  always_comb begin
    logic [7:0] n;
    logic [7:0] v;
    logic [7:0] u;
    logic [7:0] q;
    n = 8'h00;
    v = 8'h00;
    u = 8'h00;
    q = 8'h00;
    for (int i = 0; i < `RRI_NREG; i++) begin
      n = regs_r[i];
      if (wr_pend_r && (wr_idx_r == 6'(i))) begin
        n = hwdata[7:0];
      end
      case (init_cause)
        RRI_CAUSE_POR: begin
          v = INIT_TAB[i].por_v;
          u = INIT_TAB[i].por_u;
          q = INIT_TAB[i].por_q;
        end
        RRI_CAUSE_EXT: begin
          v = INIT_TAB[i].ext_v;
          u = INIT_TAB[i].ext_u;
          q = INIT_TAB[i].ext_q;
        end
        default: begin
          v = INIT_TAB[i].wk_v;
          u = INIT_TAB[i].wk_u;
          q = INIT_TAB[i].wk_q;
        end
      endcase
      if (srst) begin
        // Unknown bits have no reset value of their own, so they start from zero.
        n = (INIT_TAB[i].por_v & ~INIT_TAB[i].por_u & ~INIT_TAB[i].por_q) |
            (cond_val[i] & INIT_TAB[i].por_q);
      end else if (apply) begin
        n = (regs_r[i] & u) | (v & ~u & ~q) | (cond_val[i] & q);
      end
      // Hardware sets are applied last so an event loses to no clear except srst.
      if (!srst && (i == `RRI_IDX_INT_CTL)) begin
        n = n | (int_flag_set & `RRI_INT_FLAG_MASK);
      end
      if (!srst && (i == `RRI_IDX_PERIPH_FLAG)) begin
        n = n | periph_flag_set;
      end
      n = n & INIT_TAB[i].impl;
      if ((i == `RRI_IDX_PA_LATCH) || (i == `RRI_IDX_PA_DIR)) begin
        n = n & pa_mask;
      end
      regs_nxt[i] = n;
    end
  end

  // Stored registers. The pin image lives in the synchroniser, not here.
  always_ff @(posedge clk) begin
    for (int i = 0; i < `RRI_NREG; i++) begin
      regs_r[i] <= regs_nxt[i];
    end
  end

  // Pin synchroniser; only the second stage is read.
  always_ff @(posedge clk) begin
    pins_meta_r <= port_a_pins;
    pins_sync_r <= pins_meta_r;
  end

  // Read selection. Indices 0x22 to 0x26, past the stored array, are live views.
  assign rd_in_array = (addr_idx < 6'(`RRI_NREG)) && (addr_idx != `RRI_IDX_PA_PINS);
  assign rd_array = rd_in_array ? regs_nxt[addr_idx[5:0]] : 8'h00;
  assign rd_byte = rd_in_array ? rd_array :
                   (addr_idx == `RRI_IDX_PA_PINS) ? (pins_sync_r & pa_mask) :
                   (addr_idx == `RRI_IDX_STK_UPPER) ? {3'h0, wk_if.stack_top[20:16]} :
                   (addr_idx == `RRI_IDX_STK_HIGH) ? wk_if.stack_top[15:8] :
                   (addr_idx == `RRI_IDX_STK_LOW) ? wk_if.stack_top[7:0] :
                   (addr_idx == `RRI_IDX_STK_PTR) ? wk_if.stack_ptr :
                   8'h00;

  // Address phase capture. Reads use the next register values, so a read right
  // behind a write to the same register returns the written data.
  always_ff @(posedge clk) begin
    if (srst) begin
      wr_pend_r <= 1'b0;
      wr_idx_r <= 6'h00;
      hrdata_r <= 32'h00000000;
    end else begin
      wr_pend_r <= addr_phase && hwrite && (hsize == `RRI_HSIZE_WORD) && rd_in_array &&
                   (haddr[31:`RRI_IDX_MSB+1] == '0);
      wr_idx_r <= addr_idx;
      if (addr_phase && !hwrite) begin
        hrdata_r <= (haddr[31:`RRI_IDX_MSB+1] == '0) ? {24'h000000, rd_byte} : 32'h00000000;
      end
    end
  end

  // The slave never stalls and always answers OKAY.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;

  // Wake and stack handling.
  assign wk_if.apply = apply && !srst;
  assign wk_if.cause = init_cause;
  assign wk_if.cur_pc = current_pc;
  assign wk_if.gie_high = regs_r[`RRI_IDX_INT_CTL][`RRI_GIE_HIGH_BIT];
  assign wk_if.gie_low = regs_r[`RRI_IDX_INT_CTL][`RRI_GIE_LOW_BIT];
  assign wk_if.irq_high_prio = irq_high_prio;

  rri_wake rri_wake_i (
    .clk(clk),
    .srst(srst),
    .wk(wk_if.wake)
  );

  // Load strobe marks the cycle in which the target address is valid.
  always_ff @(posedge clk) begin
    if (srst) begin
      pc_load_r <= 1'b0;
    end else begin
      pc_load_r <= apply;
    end
  end

  assign pc_load = pc_load_r;
  assign pc_load_addr = wk_if.pc_load_addr;
  assign stack_top = wk_if.stack_top;
  assign return_stack_pointer = wk_if.stack_ptr;
  assign high_priority_global_enable = regs_r[`RRI_IDX_INT_CTL][`RRI_GIE_HIGH_BIT];
  assign low_priority_global_enable = regs_r[`RRI_IDX_INT_CTL][`RRI_GIE_LOW_BIT];
  assign analog_pin_select = regs_r[`RRI_IDX_ANALOG_CFG][2:0];
  assign port_a_latch = regs_r[`RRI_IDX_PA_LATCH] & pa_mask;
  assign port_a_direction = regs_r[`RRI_IDX_PA_DIR] & pa_mask;
endmodule
`default_nettype wire

//--- shared/rri_map.svh
`ifndef RRI_MAP_SVH
`define RRI_MAP_SVH

// Register indices; the byte address of a register is four times its index.
`define RRI_IDX_IND1_HI 6'h00
`define RRI_IDX_IND1_LO 6'h01
`define RRI_IDX_BANK 6'h02
`define RRI_IDX_IND2_DATA 6'h03
`define RRI_IDX_IND2_POSTINC 6'h04
`define RRI_IDX_IND2_POSTDEC 6'h05
`define RRI_IDX_IND2_PREINC 6'h06
`define RRI_IDX_IND2_PLUSW 6'h07
`define RRI_IDX_IND2_HI 6'h08
`define RRI_IDX_IND2_LO 6'h09
`define RRI_IDX_ALU 6'h0a
`define RRI_IDX_TMR0_HI 6'h0b
`define RRI_IDX_TMR0_LO 6'h0c
`define RRI_IDX_TMR0_CTL 6'h0d
`define RRI_IDX_OSC_CTL 6'h0e
`define RRI_IDX_VDET_CTL 6'h0f
`define RRI_IDX_WDOG_CTL 6'h10
`define RRI_IDX_RCAUSE 6'h11
`define RRI_IDX_TMR1_HI 6'h12
`define RRI_IDX_TMR1_LO 6'h13
`define RRI_IDX_TMR1_CTL 6'h14
`define RRI_IDX_TIMER_TWO_COUNT_CNT 6'h15
`define RRI_IDX_TIMER_TWO_COUNT_PER 6'h16
`define RRI_IDX_TIMER_TWO_COUNT_CTL 6'h17
`define RRI_IDX_SP_BUF 6'h18
`define RRI_IDX_SP_ADDR 6'h19
`define RRI_IDX_SP_STATE 6'h1a
`define RRI_IDX_SP_CTL1 6'h1b
`define RRI_IDX_SP_CTL2 6'h1c
`define RRI_IDX_INT_CTL 6'h1d
`define RRI_IDX_PERIPH_FLAG 6'h1e
`define RRI_IDX_ANALOG_CFG 6'h1f
`define RRI_IDX_PA_LATCH 6'h20
`define RRI_IDX_PA_DIR 6'h21
`define RRI_IDX_PA_PINS 6'h22
`define RRI_IDX_STK_UPPER 6'h23
`define RRI_IDX_STK_HIGH 6'h24
`define RRI_IDX_STK_LOW 6'h25
`define RRI_IDX_STK_PTR 6'h26
`define RRI_NREG 34
`define RRI_IDX_MSB 7

// Init entries: impl, then value, unchanged mask and condition mask per set (por, ext, wake).
`define RRI_INIT_NONE 80'h00_00_00_00_00_00_00_00_00_00
`define RRI_INIT_NIB_ZERO 80'h0f_00_00_00_00_00_00_00_0f_00
`define RRI_INIT_KEEP_ALL 80'hff_00_ff_00_00_ff_00_00_ff_00
`define RRI_INIT_ALU 80'h1f_00_1f_00_00_1f_00_00_1f_00
`define RRI_INIT_BYTE_ZERO 80'hff_00_00_00_00_00_00_00_ff_00
`define RRI_INIT_BYTE_ONES 80'hff_ff_00_00_ff_00_00_00_ff_00
`define RRI_INIT_OSC 80'hff_40_00_08_40_00_08_00_f7_08
`define RRI_INIT_VDET 80'hbf_05_00_00_05_00_00_00_bf_00
`define RRI_INIT_WDOG 80'h01_00_00_00_00_00_00_00_01_00
`define RRI_INIT_RCAUSE 80'hdf_1c_00_42_00_03_5c_00_93_4c
`define RRI_INIT_TMR1_CTL 80'hff_00_00_00_00_bf_00_00_ff_00
`define RRI_INIT_TIMER_TWO_COUNT_PER 80'hff_ff_00_00_ff_00_00_ff_00_00
`define RRI_INIT_TIMER_TWO_COUNT_CTL 80'h7f_00_00_00_00_00_00_00_7f_00
`define RRI_INIT_INT_CTL 80'hff_00_01_00_00_01_00_00_ff_00
`define RRI_INIT_ANALOG 80'h3f_00_00_07_00_00_07_00_3f_00

// Field positions and values.
`define RRI_GIE_HIGH_BIT 7
`define RRI_GIE_LOW_BIT 6
`define RRI_INT_FLAG_MASK 8'h07
`define RRI_OSC_COND_BIT 3
`define RRI_ANALOG_FUSE_SET 8'h00
`define RRI_ANALOG_FUSE_CLR 8'h07
`define RRI_PA_FULL_MASK 8'hff
`define RRI_PA_LOW_MASK 8'h3f
`define RRI_PC_W 21
`define RRI_VEC_HIGH 21'h000008
`define RRI_VEC_LOW 21'h000018
`define RRI_PC_STEP 21'h000002
`define RRI_PC_RESET 21'h000000
`define RRI_STK_PTR_MASK 8'h1f
`define RRI_STK_FLAG_MASK 8'hc0
`define RRI_STK_IMPL 8'hdf
`define RRI_STK_ONE 8'h01
`define RRI_HTRANS_NONSEQ 1'b1
`define RRI_HSIZE_WORD 3'h2

`endif

//--- shared/rri_pkg.sv
`default_nettype none
package rri_pkg;
  // Cause of the event that loads the registers.
  typedef enum logic [1:0] {
    RRI_CAUSE_POR,
    RRI_CAUSE_EXT,
    RRI_CAUSE_WAKE_WDT,
    RRI_CAUSE_WAKE_IRQ
  } rri_cause_t;

  // One register's initialization entry.
  typedef struct packed {
    logic [7:0] impl;
    logic [7:0] por_v;
    logic [7:0] por_u;
    logic [7:0] por_q;
    logic [7:0] ext_v;
    logic [7:0] ext_u;
    logic [7:0] ext_q;
    logic [7:0] wk_v;
    logic [7:0] wk_u;
    logic [7:0] wk_q;
  } rri_init_t;
endpackage
`default_nettype wire

//--- shared/rri_wake_if.sv
`default_nettype none
`include "rri_map.svh"
interface rri_wake_if;
  import rri_pkg::*;
  logic apply;
  rri_cause_t cause;
  logic [`RRI_PC_W-1:0] cur_pc;
  logic gie_high;
  logic gie_low;
  logic irq_high_prio;
  logic [`RRI_PC_W-1:0] pc_load_addr;
  logic [`RRI_PC_W-1:0] stack_top;
  logic [7:0] stack_ptr;

  modport ctrl (output apply, cause, cur_pc, gie_high, gie_low, irq_high_prio,
                input pc_load_addr, stack_top, stack_ptr);
  modport wake (input apply, cause, cur_pc, gie_high, gie_low, irq_high_prio,
                output pc_load_addr, stack_top, stack_ptr);
endinterface
`default_nettype wire

//--- hw/rri_wake.sv
`default_nettype none
`include "rri_map.svh"
module rri_wake
  import rri_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic srst,
  // Link to the register block.
  rri_wake_if.wake wk
);
  logic [`RRI_PC_W-1:0] pc_r, pc_nxt;
  logic [`RRI_PC_W-1:0] tos_r, tos_nxt;
  logic [7:0] stk_r, stk_nxt;
  wire redirect_high;
  wire redirect_low;
  wire redirect;
  wire [7:0] stk_inc;

  // A redirect needs an interrupt wake with the matching global enable set.
  assign redirect_high = (wk.cause == RRI_CAUSE_WAKE_IRQ) && wk.irq_high_prio && wk.gie_high;
  assign redirect_low = (wk.cause == RRI_CAUSE_WAKE_IRQ) && !wk.irq_high_prio && wk.gie_low;
  assign redirect = redirect_high || redirect_low;
  // The pointer wraps inside its five bits; overflow handling belongs to the core.
  assign stk_inc = (stk_r & `RRI_STK_FLAG_MASK) | (8'(stk_r + `RRI_STK_ONE) & `RRI_STK_PTR_MASK);

  // Program counter target, stack top and pointer for each cause.
  always_comb begin
    pc_nxt = pc_r;
    tos_nxt = tos_r;
    stk_nxt = stk_r;
    if (srst) begin
      pc_nxt = `RRI_PC_RESET;
      tos_nxt = `RRI_PC_RESET;
      stk_nxt = 8'h00;
    end else if (wk.apply) begin
      case (wk.cause)
        RRI_CAUSE_POR: begin
          pc_nxt = `RRI_PC_RESET;
          tos_nxt = `RRI_PC_RESET;
          stk_nxt = 8'h00;
        end
        RRI_CAUSE_EXT: begin
          pc_nxt = `RRI_PC_RESET;
          tos_nxt = `RRI_PC_RESET;
          stk_nxt = stk_r & `RRI_STK_FLAG_MASK;
        end
        default: begin
          pc_nxt = `RRI_PC_W'(wk.cur_pc + `RRI_PC_STEP);
          if (redirect_high) begin
            pc_nxt = `RRI_VEC_HIGH;
          end else if (redirect_low) begin
            pc_nxt = `RRI_VEC_LOW;
          end
          if (redirect) begin
            tos_nxt = wk.cur_pc;
            stk_nxt = stk_inc & `RRI_STK_IMPL;
          end
        end
      endcase
    end
  end

  // State registers.
  always_ff @(posedge clk) begin
    pc_r <= pc_nxt;
    tos_r <= tos_nxt;
    stk_r <= stk_nxt;
  end

  assign wk.pc_load_addr = pc_r;
  assign wk.stack_top = tos_r;
  assign wk.stack_ptr = stk_r;
endmodule
`default_nettype wire

//--- test/rri_assertions.sv
`default_nettype none
`include "rri_map.svh"
module rri_assertions
  import rri_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic srst,
  // Event inputs.
  input wire logic init_req,
  input wire rri_cause_t init_cause,
  input wire logic irq_high_prio,
  input wire logic [`RRI_PC_W-1:0] current_pc,
  input wire logic [7:0] int_flag_set,
  input wire logic [7:0] periph_flag_set,
  input wire logic port_b_analog_fuse,
  input wire logic osc_frees_pa67,
  // Results.
  input wire logic pc_load,
  input wire logic [`RRI_PC_W-1:0] pc_load_addr,
  input wire logic [`RRI_PC_W-1:0] stack_top,
  input wire logic [7:0] return_stack_pointer,
  input wire logic high_priority_global_enable,
  input wire logic low_priority_global_enable,
  input wire logic [2:0] analog_pin_select,
  input wire logic [7:0] port_a_latch,
  input wire logic [7:0] port_a_direction
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // Only a flag raised in the same cycle is visible here, so stored flags are left to the bench.
  logic redir;
  logic hard;
  assign redir = init_req && init_cause == RRI_CAUSE_WAKE_IRQ && (|int_flag_set[2:0] || |periph_flag_set)
    && (irq_high_prio ? high_priority_global_enable : low_priority_global_enable);
  assign hard = init_req && (init_cause == RRI_CAUSE_POR || init_cause == RRI_CAUSE_EXT);

  property p_vec_high;
    redir && irq_high_prio |=> pc_load && pc_load_addr == `RRI_VEC_HIGH;
  endproperty
  a_vec_high: assert property (p_vec_high) else $error("high vector not loaded");
  property p_vec_low;
    redir && !irq_high_prio |=> pc_load && pc_load_addr == `RRI_VEC_LOW;
  endproperty
  a_vec_low: assert property (p_vec_low) else $error("low vector not loaded");
  property p_push;
    redir |=> stack_top == $past(current_pc) && return_stack_pointer[4:0] == $past(return_stack_pointer[4:0]) + 5'h01;
  endproperty
  a_push: assert property (p_push) else $error("stack push wrong");
  property p_wdt_pc;
    init_req && init_cause == RRI_CAUSE_WAKE_WDT |=> pc_load && pc_load_addr == $past(current_pc) + `RRI_PC_STEP;
  endproperty
  a_wdt_pc: assert property (p_wdt_pc) else $error("watchdog wake address wrong");
  property p_hard_pc;
    hard |=> pc_load && pc_load_addr == `RRI_PC_RESET && stack_top == 21'h0 && !high_priority_global_enable;
  endproperty
  a_hard_pc: assert property (p_hard_pc) else $error("reset set not applied");
  property p_no_req;
    !init_req |=> !pc_load;
  endproperty
  a_no_req: assert property (p_no_req) else $error("load without request");
  property p_pa_gate;
    !osc_frees_pa67 |-> port_a_latch[7:6] == 2'h0 && port_a_direction[7:6] == 2'h0;
  endproperty
  a_pa_gate: assert property (p_pa_gate) else $error("port A upper bits not zero");
  property p_fuse;
    hard |=> analog_pin_select == ($past(port_b_analog_fuse) ? 3'h0 : 3'h7);
  endproperty
  a_fuse: assert property (p_fuse) else $error("analog select wrong");
  property p_rst;
    $fell(srst) |-> analog_pin_select == ($past(port_b_analog_fuse) ? 3'h0 : 3'h7) && !pc_load
      && return_stack_pointer == 8'h00 && !low_priority_global_enable;
  endproperty
  a_rst: assert property (p_rst) else $error("power-on values wrong");

  // Main scenarios.
  c_high: cover property (redir && irq_high_prio);
  c_low: cover property (redir && !irq_high_prio);
  c_wdt: cover property (init_req && init_cause == RRI_CAUSE_WAKE_WDT);
endmodule

bind rri_top rri_assertions rri_assertions_i (.clk, .srst, .init_req, .init_cause, .irq_high_prio, .current_pc,
  .int_flag_set, .periph_flag_set, .port_b_analog_fuse, .osc_frees_pa67, .pc_load, .pc_load_addr, .stack_top,
  .return_stack_pointer, .high_priority_global_enable, .low_priority_global_enable, .analog_pin_select,
  .port_a_latch, .port_a_direction);
`default_nettype wire

//--- test/tb_top.sv
`default_nettype none
`include "rri_map.svh"
module tb_top
  import rri_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] hwdata = 32'h0;
  logic hready;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic init_req = 1'b0;
  rri_cause_t init_cause = RRI_CAUSE_POR;
  logic irq_high_prio = 1'b0;
  logic [20:0] current_pc = 21'h0;
  logic [7:0] int_flag_set = 8'h0;
  logic [7:0] periph_flag_set = 8'h0;
  logic osc_cond_bit = 1'b1;
  logic [7:0] reset_cause_cond = 8'hff;
  logic port_b_analog_fuse = 1'b1;
  logic osc_frees_pa67 = 1'b1;
  logic [7:0] port_a_pins = 8'h0;
  logic pc_load;
  logic [20:0] pc_load_addr;
  logic [20:0] stack_top;
  logic [7:0] return_stack_pointer;
  logic [2:0] analog_pin_select;
  logic [7:0] port_a_latch;
  logic [7:0] port_a_direction;
  int bad_count = 0;
  int checked = 0;
  logic [31:0] rd;
  logic pl;
  logic [20:0] pa;
  // All-ones writes and what must read back.
  logic [5:0] wi [8] = '{`RRI_IDX_IND1_HI, `RRI_IDX_BANK, `RRI_IDX_ALU, `RRI_IDX_TIMER_TWO_COUNT_CTL, `RRI_IDX_WDOG_CTL,
    `RRI_IDX_IND2_DATA, `RRI_IDX_PA_PINS, `RRI_IDX_STK_PTR};
  logic [7:0] we [8] = '{8'h0f, 8'h0f, 8'h1f, 8'h7f, 8'h01, 8'h00, 8'h00, 8'h00};

  // The single slave's ready is the bus ready.
  assign hready = hreadyout;
  always #2 clk = ~clk;

  rri_top rri_top_i (.clk, .srst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout,
    .hresp, .hrdata, .init_req, .init_cause, .irq_high_prio, .current_pc, .int_flag_set, .periph_flag_set,
    .osc_cond_bit, .reset_cause_cond, .port_b_analog_fuse, .osc_frees_pa67, .port_a_pins, .pc_load,
    .pc_load_addr, .stack_top, .return_stack_pointer, .high_priority_global_enable(),
    .low_priority_global_enable(), .analog_pin_select, .port_a_latch, .port_a_direction);

  task automatic close_out();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
      bad_count++;
    end
  endtask

  // A bounded wait, so a stuck slave ends the run instead of hanging it.
  task automatic edge_ready();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 40);
    if (hreadyout !== 1'b1) begin
      bad_count++;
      close_out();
    end
  endtask

  task automatic bus(input logic wr, input logic [5:0] idx, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, idx, 2'h0};
    hwrite <= wr;
    hsize <= `RRI_HSIZE_WORD;
    edge_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    edge_ready();
    rd = hrdata;
  endtask

  task automatic rchk(input logic [5:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 32'h0);
    chk($sformatf("reg_%0h", idx), {24'h0, exp}, rd);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask

  task automatic init(input rri_cause_t c, input logic [20:0] pc, input logic [7:0] fl, input logic [7:0] pf);
    init_req <= 1'b1;
    init_cause <= c;
    current_pc <= pc;
    int_flag_set <= fl;
    periph_flag_set <= pf;
    @(posedge clk);
    init_req <= 1'b0;
    int_flag_set <= 8'h0;
    periph_flag_set <= 8'h0;
    @(posedge clk);
    pl = pc_load;
    pa = pc_load_addr;
  endtask

  function automatic logic [7:0] por_val(input logic [5:0] i);
    case (i)
      `RRI_IDX_TMR0_CTL, `RRI_IDX_TIMER_TWO_COUNT_PER, `RRI_IDX_PA_DIR: por_val = 8'hff;
      `RRI_IDX_OSC_CTL: por_val = 8'h48;
      `RRI_IDX_VDET_CTL: por_val = 8'h05;
      `RRI_IDX_RCAUSE: por_val = 8'h5e;
      default: por_val = 8'h00;
    endcase
  endfunction

  // Main sequence; each step leaves the bench just after a rising edge.
  initial begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 41; i++) rchk(i[5:0], por_val(i[5:0]));
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, wi[i], 32'hffff_ffff);
      rchk(wi[i], we[i]);
    end
    bus(1'b1, `RRI_IDX_IND1_LO, 32'ha5);
    bus(1'b1, `RRI_IDX_PA_LATCH, 32'hff);
    port_b_analog_fuse <= 1'b0;
    osc_cond_bit <= 1'b0;
    init(RRI_CAUSE_EXT, 21'h01555, 8'h0, 8'h0);
    chk("pc_load", 32'h1, {31'h0, pl});
    chk("pc_addr", 32'h0, {11'h0, pa});
    rchk(`RRI_IDX_IND1_LO, 8'ha5);
    rchk(`RRI_IDX_IND1_HI, 8'h00);
    rchk(`RRI_IDX_TIMER_TWO_COUNT_CTL, 8'h00);
    rchk(`RRI_IDX_OSC_CTL, 8'h40);
    rchk(`RRI_IDX_ANALOG_CFG, 8'h07);
    rchk(`RRI_IDX_PA_LATCH, 8'hff);
    osc_frees_pa67 <= 1'b0;
    @(posedge clk);
    chk("pa_latch_pin", 32'h3f, {24'h0, port_a_latch});
    rchk(`RRI_IDX_PA_LATCH, 8'h3f);
    rchk(`RRI_IDX_PA_DIR, 8'h3f);
    osc_frees_pa67 <= 1'b1;
    bus(1'b1, `RRI_IDX_IND1_HI, 32'h05);
    bus(1'b1, `RRI_IDX_TIMER_TWO_COUNT_PER, 32'h10);
    init(RRI_CAUSE_WAKE_WDT, 21'h01234, 8'h0, 8'h0);
    chk("wdt_addr", 32'h1236, {11'h0, pa});
    rchk(`RRI_IDX_IND1_HI, 8'h05);
    rchk(`RRI_IDX_TIMER_TWO_COUNT_PER, 8'hff);
    bus(1'b1, `RRI_IDX_INT_CTL, 32'hc0);
    init(RRI_CAUSE_WAKE_IRQ, 21'h00100, 8'h0, 8'h0);
    chk("no_flag_load", 32'h0, {31'h0, pl});
    irq_high_prio <= 1'b1;
    init(RRI_CAUSE_WAKE_IRQ, 21'h00100, 8'h01, 8'h0);
    chk("high_addr", 32'h8, {11'h0, pa});
    chk("stack_top", 32'h100, {11'h0, stack_top});
    chk("stack_ptr", 32'h1, {24'h0, return_stack_pointer});
    irq_high_prio <= 1'b0;
    init(RRI_CAUSE_WAKE_IRQ, 21'h1abcd, 8'h0, 8'h01);
    chk("low_addr", 32'h18, {11'h0, pa});
    rchk(`RRI_IDX_STK_UPPER, 8'h01);
    rchk(`RRI_IDX_STK_HIGH, 8'hab);
    rchk(`RRI_IDX_STK_LOW, 8'hcd);
    rchk(`RRI_IDX_STK_PTR, 8'h02);
    rchk(`RRI_IDX_INT_CTL, 8'hc1);
    bus(1'b1, `RRI_IDX_INT_CTL, 32'h0);
    init(RRI_CAUSE_WAKE_IRQ, 21'h00300, 8'h02, 8'h0);
    chk("plain_addr", 32'h302, {11'h0, pa});
    chk("ptr_kept", 32'h2, {24'h0, return_stack_pointer});
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rchk(`RRI_IDX_STK_PTR, 8'h00);
    rchk(`RRI_IDX_ANALOG_CFG, 8'h07);
    rchk(`RRI_IDX_PA_LATCH, 8'h00);
    close_out();
  end
endmodule
`default_nettype wire
